// ---- verilog/bevc_pkg.sv ----
`default_nettype none
package bevc_pkg;
  localparam int unsigned BEVC_GROUPS = 4;
  localparam int unsigned BEVC_AW = 24;
  localparam int unsigned BEVC_DW = 16;
  localparam int unsigned BEVC_SW = 16;
  localparam int unsigned BEVC_CW = 16;
  localparam int unsigned BEVC_GW = 2;
  // Register address map: addr[7:6] group, addr[5:0] register within group
  localparam logic [7:0] BEVC_GRP_SHIFT = 8'h06;
  localparam logic [5:0] BEVC_R_ADDR_A_LO = 6'h00;
  localparam logic [5:0] BEVC_R_ADDR_A_HI = 6'h01;
  localparam logic [5:0] BEVC_R_ADDR_A_MODE = 6'h02;
  localparam logic [5:0] BEVC_R_ADDR_B_LO = 6'h03;
  localparam logic [5:0] BEVC_R_ADDR_B_HI = 6'h04;
  localparam logic [5:0] BEVC_R_ADDR_B_MODE = 6'h05;
  localparam logic [5:0] BEVC_R_DATA_A = 6'h06;
  localparam logic [5:0] BEVC_R_DATA_A_MASK = 6'h07;
  localparam logic [5:0] BEVC_R_DATA_B = 6'h08;
  localparam logic [5:0] BEVC_R_DATA_B_MASK = 6'h09;
  localparam logic [5:0] BEVC_R_KIND_A = 6'h0a;
  localparam logic [5:0] BEVC_R_KIND_A_MASK = 6'h0b;
  localparam logic [5:0] BEVC_R_KIND_B = 6'h0c;
  localparam logic [5:0] BEVC_R_KIND_B_MASK = 6'h0d;
  localparam logic [5:0] BEVC_R_PROBE = 6'h0e;
  localparam logic [5:0] BEVC_R_PROBE_MASK = 6'h0f;
  localparam logic [5:0] BEVC_R_LIMIT = 6'h10;
  // Global registers, decoded at the same offset in every group space
  localparam logic [5:0] BEVC_R_STATUS = 6'h20;
  localparam logic [5:0] BEVC_R_COUNT = 6'h21;
  // Address mode encodings (2 bits)
  localparam logic [1:0] BEVC_MODE_SINGLE = 2'h0;
  localparam logic [1:0] BEVC_MODE_INSIDE = 2'h1;
  localparam logic [1:0] BEVC_MODE_OUTSIDE = 2'h2;
  localparam logic [1:0] BEVC_MODE_SPAN = 2'h3;
  localparam logic [15:0] BEVC_MASK_RST = 16'hffff;
  localparam logic [15:0] BEVC_ZERO16 = 16'h0000;
endpackage
`default_nettype wire

// ---- verilog/bevc_top.sv ----
// Summary of operation
// - four groups of seven comparators each
// - address comparators see full 24-bit address
// - single, inside range, outside range modes
// - inside range includes both bounds
// - span form without prefix is inside
// - outside matches at/below low, at/above high
// - per-group limits, one shared pass counter
// - run entry loads group zero limit
// - reload plus switch loads target limit
// - data comparators with value and ignore mask
// - form 16-bit cycle status word
// - status comparator matches on enabled bits
// - status word carries cycle attributes
// - matches combine with AND and OR; here match_o carries raw hits and the caller combines them
// - mask ones ignored, overlap means ignored
// - address and limit match exactly, no mask
// - only one group active at a time
// - decrement action counts once per event
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/10ps
`default_nettype none
module bevc_top (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  input wire logic run_mode_i,
  input wire logic cycle_valid_i,
  input wire logic [23:0] cycle_addr_i,
  input wire logic [15:0] cycle_data_i,
  input wire logic [7:0] cpu_status_i,
  input wire logic [7:0] emu_status_i,
  input wire logic [15:0] probe_i,
  input wire logic counter_decrement_action_i,
  input wire logic counter_reload_action_i,
  input wire logic group_switch_action_i,
  input wire logic [1:0] group_switch_target_i,
  output logic [1:0] active_group_o,
  output logic [7:0] match_o,
  output logic match_valid_o,
  output logic [15:0] cycle_kind_word_o,
  output logic [15:0] pass_count_o
);
  localparam int unsigned NG = bevc_pkg::BEVC_GROUPS;

  // Per-group storage
  logic [23:0] addr_a_lo [NG];
  logic [23:0] addr_a_hi [NG];
  logic [23:0] addr_b_lo [NG];
  logic [23:0] addr_b_hi [NG];
  logic [1:0] addr_a_mode [NG];
  logic [1:0] addr_b_mode [NG];
  logic [15:0] data_a [NG];
  logic [15:0] data_a_mask [NG];
  logic [15:0] data_b [NG];
  logic [15:0] data_b_mask [NG];
  logic [15:0] kind_a [NG];
  logic [15:0] kind_a_mask [NG];
  logic [15:0] kind_b [NG];
  logic [15:0] kind_b_mask [NG];
  logic [15:0] probe_val [NG];
  logic [15:0] probe_mask [NG];
  logic [15:0] limit [NG];
  logic [NG-1:0] grp_wr;
  logic [NG-1:0][15:0] grp_rdata;

  wire [1:0] reg_grp = reg_addr_i[7:6];
  wire [5:0] reg_off = reg_addr_i[5:0];

  // Upper address byte sits in mode word bits 11:4, shared by both bounds to save a register
  genvar g;
  generate
    for (g = 0; g < NG; g++) begin : gen_grp
      assign grp_wr[g] = reg_wr_i && (reg_grp == 2'(g));
      always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          addr_a_lo[g] <= 24'h00_0000;
          addr_a_hi[g] <= 24'h00_0000;
          addr_b_lo[g] <= 24'h00_0000;
          addr_b_hi[g] <= 24'h00_0000;
          addr_a_mode[g] <= bevc_pkg::BEVC_MODE_SINGLE;
          addr_b_mode[g] <= bevc_pkg::BEVC_MODE_SINGLE;
          data_a[g] <= bevc_pkg::BEVC_ZERO16;
          data_b[g] <= bevc_pkg::BEVC_ZERO16;
          kind_a[g] <= bevc_pkg::BEVC_ZERO16;
          kind_b[g] <= bevc_pkg::BEVC_ZERO16;
          probe_val[g] <= bevc_pkg::BEVC_ZERO16;
          data_a_mask[g] <= bevc_pkg::BEVC_MASK_RST;
          data_b_mask[g] <= bevc_pkg::BEVC_MASK_RST;
          kind_a_mask[g] <= bevc_pkg::BEVC_MASK_RST;
          kind_b_mask[g] <= bevc_pkg::BEVC_MASK_RST;
          probe_mask[g] <= bevc_pkg::BEVC_MASK_RST;
          limit[g] <= bevc_pkg::BEVC_ZERO16;
        end else if (grp_wr[g]) begin
          unique case (reg_off)
            bevc_pkg::BEVC_R_ADDR_A_LO: addr_a_lo[g][15:0] <= reg_wdata_i;
            bevc_pkg::BEVC_R_ADDR_A_HI: addr_a_hi[g][15:0] <= reg_wdata_i;
            bevc_pkg::BEVC_R_ADDR_A_MODE: begin
              addr_a_mode[g] <= reg_wdata_i[1:0];
              addr_a_lo[g][23:16] <= reg_wdata_i[11:4];
              addr_a_hi[g][23:16] <= reg_wdata_i[11:4];
            end
            bevc_pkg::BEVC_R_ADDR_B_LO: addr_b_lo[g][15:0] <= reg_wdata_i;
            bevc_pkg::BEVC_R_ADDR_B_HI: addr_b_hi[g][15:0] <= reg_wdata_i;
            bevc_pkg::BEVC_R_ADDR_B_MODE: begin
              addr_b_mode[g] <= reg_wdata_i[1:0];
              addr_b_lo[g][23:16] <= reg_wdata_i[11:4];
              addr_b_hi[g][23:16] <= reg_wdata_i[11:4];
            end
            bevc_pkg::BEVC_R_DATA_A: data_a[g] <= reg_wdata_i;
            bevc_pkg::BEVC_R_DATA_A_MASK: data_a_mask[g] <= reg_wdata_i;
            bevc_pkg::BEVC_R_DATA_B: data_b[g] <= reg_wdata_i;
            bevc_pkg::BEVC_R_DATA_B_MASK: data_b_mask[g] <= reg_wdata_i;
            bevc_pkg::BEVC_R_KIND_A: kind_a[g] <= reg_wdata_i;
            bevc_pkg::BEVC_R_KIND_A_MASK: kind_a_mask[g] <= reg_wdata_i;
            bevc_pkg::BEVC_R_KIND_B: kind_b[g] <= reg_wdata_i;
            bevc_pkg::BEVC_R_KIND_B_MASK: kind_b_mask[g] <= reg_wdata_i;
            bevc_pkg::BEVC_R_PROBE: probe_val[g] <= reg_wdata_i;
            bevc_pkg::BEVC_R_PROBE_MASK: probe_mask[g] <= reg_wdata_i;
            bevc_pkg::BEVC_R_LIMIT: limit[g] <= reg_wdata_i;
            default: ;
          endcase
        end
      end
      always_comb begin
        unique case (reg_off)
          bevc_pkg::BEVC_R_ADDR_A_LO: grp_rdata[g] = addr_a_lo[g][15:0];
          bevc_pkg::BEVC_R_ADDR_A_HI: grp_rdata[g] = addr_a_hi[g][15:0];
          bevc_pkg::BEVC_R_ADDR_A_MODE:
            grp_rdata[g] = {4'h0, addr_a_lo[g][23:16], 2'h0, addr_a_mode[g]};
          bevc_pkg::BEVC_R_ADDR_B_LO: grp_rdata[g] = addr_b_lo[g][15:0];
          bevc_pkg::BEVC_R_ADDR_B_HI: grp_rdata[g] = addr_b_hi[g][15:0];
          bevc_pkg::BEVC_R_ADDR_B_MODE:
            grp_rdata[g] = {4'h0, addr_b_lo[g][23:16], 2'h0, addr_b_mode[g]};
          bevc_pkg::BEVC_R_DATA_A: grp_rdata[g] = data_a[g];
          bevc_pkg::BEVC_R_DATA_A_MASK: grp_rdata[g] = data_a_mask[g];
          bevc_pkg::BEVC_R_DATA_B: grp_rdata[g] = data_b[g];
          bevc_pkg::BEVC_R_DATA_B_MASK: grp_rdata[g] = data_b_mask[g];
          bevc_pkg::BEVC_R_KIND_A: grp_rdata[g] = kind_a[g];
          bevc_pkg::BEVC_R_KIND_A_MASK: grp_rdata[g] = kind_a_mask[g];
          bevc_pkg::BEVC_R_KIND_B: grp_rdata[g] = kind_b[g];
          bevc_pkg::BEVC_R_KIND_B_MASK: grp_rdata[g] = kind_b_mask[g];
          bevc_pkg::BEVC_R_PROBE: grp_rdata[g] = probe_val[g];
          bevc_pkg::BEVC_R_PROBE_MASK: grp_rdata[g] = probe_mask[g];
          bevc_pkg::BEVC_R_LIMIT: grp_rdata[g] = limit[g];
          default: grp_rdata[g] = bevc_pkg::BEVC_ZERO16;
        endcase
      end
    end
  endgenerate

  // Address compare function: exact values, no mask
  function automatic logic addr_hit(input logic [1:0] mode, input logic [23:0] lo,
                                    input logic [23:0] hi, input logic [23:0] a);
    logic r;
    r = 1'b0;
    unique case (mode)
      bevc_pkg::BEVC_MODE_SINGLE: r = (a == lo);
      bevc_pkg::BEVC_MODE_INSIDE, bevc_pkg::BEVC_MODE_SPAN:
        r = (a >= lo) && (a <= hi);
      bevc_pkg::BEVC_MODE_OUTSIDE: r = (a <= lo) || (a >= hi);
    endcase
    return r;
  endfunction

  // Masked compare: a one in the mask always wins
  function automatic logic mask_hit(input logic [15:0] v, input logic [15:0] m,
                                    input logic [15:0] x);
    return ((v ^ x) & ~m) == 16'h0000;
  endfunction

  logic [1:0] grp;
  logic [15:0] count;
  logic run_q;
  logic zero_hit;

  // Status word: cpu bits low byte, emulator bits high byte
  wire [15:0] kind_word = {emu_status_i, cpu_status_i};

  // Only the active group's comparators are looked at
  wire hit_aa = addr_hit(addr_a_mode[grp], addr_a_lo[grp], addr_a_hi[grp], cycle_addr_i);
  wire hit_ab = addr_hit(addr_b_mode[grp], addr_b_lo[grp], addr_b_hi[grp], cycle_addr_i);
  wire hit_da = mask_hit(data_a[grp], data_a_mask[grp], cycle_data_i);
  wire hit_db = mask_hit(data_b[grp], data_b_mask[grp], cycle_data_i);
  wire hit_ka = mask_hit(kind_a[grp], kind_a_mask[grp], kind_word);
  wire hit_kb = mask_hit(kind_b[grp], kind_b_mask[grp], kind_word);
  wire hit_pr = mask_hit(probe_val[grp], probe_mask[grp], probe_i);
  wire run_rise = run_mode_i && !run_q;
  // Reload wins over decrement when both fire
  wire do_reload = cycle_valid_i && counter_reload_action_i && group_switch_action_i;
  wire do_dec = cycle_valid_i && counter_decrement_action_i && !do_reload && !zero_hit;
  wire [15:0] next_count = run_rise ? limit[0] :
                           do_reload ? limit[group_switch_target_i] :
                           do_dec ? count - 16'h0001 : count;
  wire [1:0] next_grp = run_rise ? 2'h0 :
                        (cycle_valid_i && group_switch_action_i) ? group_switch_target_i : grp;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      run_q <= 1'b0;
      grp <= 2'h0;
      count <= bevc_pkg::BEVC_ZERO16;
      zero_hit <= 1'b0;
    end else begin
      run_q <= run_mode_i;
      grp <= next_grp;
      count <= next_count;
      // Latches at zero, cleared only by run entry or a reload
      if (run_rise || do_reload) begin
        zero_hit <= 1'b0;
      end else if (do_dec && count == 16'h0001) begin
        zero_hit <= 1'b1;
      end
    end
  end

  // Match vector registered once per bus cycle; AND/OR is the caller's
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      match_o <= 8'h00;
      match_valid_o <= 1'b0;
      cycle_kind_word_o <= bevc_pkg::BEVC_ZERO16;
      reg_rdata_o <= bevc_pkg::BEVC_ZERO16;
      active_group_o <= 2'h0;
      pass_count_o <= bevc_pkg::BEVC_ZERO16;
    end else begin
      match_valid_o <= cycle_valid_i;
      if (cycle_valid_i) begin
        match_o <= {zero_hit, hit_pr, hit_kb, hit_ka, hit_db, hit_da, hit_ab, hit_aa};
        cycle_kind_word_o <= kind_word;
      end
      active_group_o <= next_grp;
      pass_count_o <= next_count;
      if (reg_rd_i) begin
        if (reg_off == bevc_pkg::BEVC_R_STATUS) begin
          reg_rdata_o <= {13'h0000, zero_hit, grp};
        end else if (reg_off == bevc_pkg::BEVC_R_COUNT) begin
          reg_rdata_o <= count;
        end else begin
          reg_rdata_o <= grp_rdata[reg_grp];
        end
      end else begin
        reg_rdata_o <= bevc_pkg::BEVC_ZERO16;
      end
    end
  end

  property p_run_load;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    run_rise |=> count == $past(limit[0]);
  endproperty
  a_run_load: assert property (p_run_load) else $error("run entry load wrong");
  property p_reload;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    do_reload && !run_rise |=> count == $past(limit[group_switch_target_i]) && !zero_hit;
  endproperty
  a_reload: assert property (p_reload) else $error("reload wrong");
  property p_dec;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    do_dec && !run_rise |=> count == $past(count) - 16'h0001;
  endproperty
  a_dec: assert property (p_dec) else $error("decrement");
  property p_zero;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    zero_hit && !run_rise && !do_reload |=> zero_hit;
  endproperty
  a_zero: assert property (p_zero) else $error("limit dropped");
  property p_grp;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    !run_rise && !(cycle_valid_i && group_switch_action_i) |=> $stable(grp);
  endproperty
  a_grp: assert property (p_grp) else $error("group changed");
  property p_valid;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    cycle_valid_i |=> match_valid_o;
  endproperty
  a_valid: assert property (p_valid) else $error("no match slot");
  property p_single;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    cycle_valid_i && addr_a_mode[grp] == bevc_pkg::BEVC_MODE_SINGLE
      && cycle_addr_i == addr_a_lo[grp] |=> match_o[0];
  endproperty
  a_single: assert property (p_single) else $error("single miss");
  property p_inside;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    cycle_valid_i && addr_b_mode[grp] == bevc_pkg::BEVC_MODE_INSIDE
      && cycle_addr_i == addr_b_hi[grp] |=> match_o[1];
  endproperty
  a_inside: assert property (p_inside) else $error("bound miss");
  property p_outside;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    cycle_valid_i && addr_b_mode[grp] == bevc_pkg::BEVC_MODE_OUTSIDE
      && cycle_addr_i == addr_b_lo[grp] |=> match_o[1];
  endproperty
  a_outside: assert property (p_outside) else $error("outside bound miss");
  property p_mask;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    cycle_valid_i && data_a_mask[grp] == 16'hffff |=> match_o[2];
  endproperty
  a_mask: assert property (p_mask) else $error("mask");
endmodule
`default_nettype wire

// ---- tb/bevc_tgt_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module bevc_tgt_model (
  input wire logic clk_i,
  output var logic valid_o,
  output var logic [23:0] addr_o,
  output var logic [15:0] data_o,
  output var logic [15:0] kind_o,
  output var logic [15:0] probe_o,
  output var logic [4:0] act_o
);
  initial begin
    valid_o = 1'b0;
    addr_o = 24'h00_0000;
    data_o = 16'h0000;
    kind_o = 16'h0000;
    probe_o = 16'h0000;
    act_o = 5'h00;
  end
  // Between cycles the lines invert on every clock, so stale values never pass as fresh
  task automatic bus_cycle(input logic [23:0] a, input logic [15:0] d, input logic [15:0] k,
      input logic [15:0] p, input logic [4:0] ac, input int gap);
    valid_o <= 1'b1;
    addr_o <= a;
    data_o <= d;
    kind_o <= k;
    probe_o <= p;
    act_o <= ac;
    @(posedge clk_i);
    for (int i = 0; i < gap; i++) begin
      valid_o <= 1'b0;
      addr_o <= ~addr_o;
      data_o <= ~data_o;
      kind_o <= ~kind_o;
      probe_o <= ~probe_o;
      act_o <= ~act_o;
      @(posedge clk_i);
    end
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_bus_event_comparators.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_bus_event_comparators;
  logic clk_sys_i = 1'b0;
  logic rst_b_i, reg_wr_i, reg_rd_i, run_mode_i, cv, zf;
  logic rd_q = 1'b0;
  logic [7:0] reg_addr_i, match_o;
  logic [15:0] reg_wdata_i, reg_rdata_o, cd, ck, cp, kword, pass_count_o, cnt;
  logic [23:0] ca;
  logic [4:0] act;
  logic [1:0] active_group_o, grp;
  logic match_valid_o;
  logic [23:0] la [4][2];
  logic [23:0] ha [4][2];
  logic [1:0] md [4][2];
  logic [15:0] val [4][5];
  logic [15:0] msk [4][5];
  logic [15:0] lim [4];
  logic [41:0] exp_m [$];
  logic [15:0] exp_r [$];
  logic [41:0] mx;
  logic [31:0] seed = 32'h789a_b98b;
  logic [31:0] r;
  logic [23:0] bnd [6] = '{24'h12_2fff, 24'h12_3000, 24'h12_3001, 24'h12_3ffe, 24'h12_3fff,
      24'h12_4000};
  int n_fail = 0;
  int compares = 0;

  always #4 clk_sys_i = ~clk_sys_i;

  bevc_top dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .run_mode_i(run_mode_i), .cycle_valid_i(cv), .cycle_addr_i(ca),
    .cycle_data_i(cd), .cpu_status_i(ck[7:0]), .emu_status_i(ck[15:8]), .probe_i(cp),
    .counter_decrement_action_i(act[0]), .counter_reload_action_i(act[1]),
    .group_switch_action_i(act[2]), .group_switch_target_i(act[4:3]),
    .active_group_o(active_group_o), .match_o(match_o), .match_valid_o(match_valid_o),
    .cycle_kind_word_o(kword), .pass_count_o(pass_count_o));

  bevc_tgt_model tgt (.clk_i(clk_sys_i), .valid_o(cv), .addr_o(ca), .data_o(cd), .kind_o(ck),
    .probe_o(cp), .act_o(act));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic am(input logic [1:0] m, input logic [23:0] lo, input logic [23:0] hi,
      input logic [23:0] a);
    if (m == bevc_pkg::BEVC_MODE_SINGLE) return a == lo;
    if (m == bevc_pkg::BEVC_MODE_OUTSIDE) return (a <= lo) || (a >= hi);
    return (a >= lo) && (a <= hi);
  endfunction

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  // Sample mid-cycle, where every registered output has settled
  always @(negedge clk_sys_i) begin
    if (match_valid_o === 1'b1) begin
      mx = exp_m.pop_front();
      chk("match_o", {8'h00, mx[7:0]}, {8'h00, match_o});
      chk("cycle_kind_word_o", mx[23:8], kword);
      chk("pass_count_o", mx[39:24], pass_count_o);
      chk("active_group_o", {14'h0000, mx[41:40]}, {14'h0000, active_group_o});
    end
    if (rd_q) chk("reg_rdata_o", exp_r.pop_front(), reg_rdata_o);
    rd_q = reg_rd_i;
  end

  task automatic bus(input logic w, input logic rd, input logic [7:0] a, input logic [15:0] d);
    reg_wr_i <= w;
    reg_rd_i <= rd;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
  endtask

  task automatic wr(input logic [1:0] g, input logic [5:0] o, input logic [15:0] d);
    bus(1'b1, 1'b0, {g, o}, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_r.push_back(e);
    bus(1'b0, 1'b1, a, 16'h0000);
  endtask

  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, reg_addr_i, 16'h0000);
  endtask

  task automatic set_addr(input logic [1:0] g, input int k, input logic [23:0] lo,
      input logic [15:0] hi, input logic [1:0] m);
    wr(g, 6'(3 * k), lo[15:0]);
    wr(g, 6'(3 * k + 1), hi);
    wr(g, 6'(3 * k + 2), {4'h0, lo[23:16], 2'b00, m});
    la[g][k] = lo;
    ha[g][k] = {lo[23:16], hi};
    md[g][k] = m;
  endtask

  task automatic set_pair(input logic [1:0] g, input int i, input logic [15:0] v,
      input logic [15:0] m);
    wr(g, 6'(6 + 2 * i), v);
    wr(g, 6'(7 + 2 * i), m);
    val[g][i] = v;
    msk[g][i] = m;
  endtask

  task automatic cyc(input logic [23:0] a, input logic [15:0] d, input logic [15:0] kw,
      input logic [15:0] p, input logic [4:0] ac, input int gap);
    logic [7:0] e;
    logic [15:0] x [5];
    x = '{d, d, kw, kw, p};
    for (int i = 0; i < 2; i++) e[i] = am(md[grp][i], la[grp][i], ha[grp][i], a);
    for (int i = 0; i < 5; i++) e[i + 2] = ((x[i] ^ val[grp][i]) & ~msk[grp][i]) == 16'h0000;
    e[7] = zf;
    if (ac[1] && ac[2]) begin
      cnt = lim[ac[4:3]];
      zf = 1'b0;
    end else if (ac[0] && !zf) begin
      cnt = cnt - 16'h0001;
      zf = (cnt == 16'h0000);
    end
    if (ac[2]) grp = ac[4:3];
    exp_m.push_back({grp, cnt, kw, e});
    tgt.bus_cycle(a, d, kw, p, ac, gap);
  endtask

  task automatic complete_run();
    if (exp_m.size() != 0 || exp_r.size() != 0) begin
      n_fail++;
      $display("MISMATCH queues expected 0 seen %0d", exp_m.size() + exp_r.size());
    end
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    #(8 * 5000);
    n_fail++;
    complete_run();
  end

  initial begin
    rst_b_i = 1'b0;
    run_mode_i = 1'b0;
    {reg_wr_i, reg_rd_i, zf} = 3'h0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 16'h0000;
    {cnt, grp} = 18'h0_0000;
    for (int g = 0; g < 4; g++) begin
      lim[g] = 16'h0000;
      for (int i = 0; i < 5; i++) {val[g][i], msk[g][i]} = {16'h0000, bevc_pkg::BEVC_MASK_RST};
      for (int k = 0; k < 2; k++) {la[g][k], ha[g][k], md[g][k]} = 50'h0;
    end
    repeat (2) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    wr(2'd0, 6'h3f, 16'hbeef);
    rd(8'h3f, 16'h0000);
    rd(8'h07, 16'hffff);
    rd(8'h21, 16'h0000);
    idle(2);
    $display("test reset done");
    set_addr(2'd0, 0, 24'h5a_4000, 16'h0000, bevc_pkg::BEVC_MODE_SINGLE);
    set_pair(2'd0, 0, 16'h0055, 16'hff00);
    set_pair(2'd0, 1, 16'hf033, 16'h0000);
    set_pair(2'd0, 2, 16'h0100, 16'hf8ff);
    set_pair(2'd0, 3, 16'h0001, 16'hfffe);
    set_pair(2'd0, 4, 16'h1234, 16'h00ff);
    wr(2'd0, 6'h10, 16'h0003);
    wr(2'd1, 6'h10, 16'h0005);
    lim[0] = 16'h0003;
    lim[1] = 16'h0005;
    rd(8'h0a, 16'h0100);
    run_mode_i <= 1'b1;
    idle(1);
    cnt = lim[0];
    rd(8'h21, 16'h0003);
    idle(1);
    $display("test setup done");
    for (int m = 1; m < 4; m++) begin
      set_addr(2'd0, 1, 24'h12_3000, 16'h3fff, 2'(m));
      idle(1);
      for (int j = 0; j < 6; j++) begin
        r = xs();
        cyc(bnd[j], r[15:0], r[31:16], 16'h1234, 5'h00, (j == 5) ? 1 : j % 2);
      end
    end
    cyc(24'h5a_4000, 16'h0055, 16'h0101, 16'h0034, 5'h00, 0);
    cyc(24'h00_4000, 16'hf033, 16'h0001, 16'h5634, 5'h00, 0);
    cyc(24'h5a_4001, 16'h0155, 16'h0200, 16'h1235, 5'h00, 1);
    for (int j = 0; j < 40; j++) begin
      r = xs();
      cyc({8'h12, r[15:0]}, r[0] ? 16'hf033 : r[31:16], r[23:8], r[31:16],
          5'h00, r[1]);
    end
    cyc(24'h00_0000, 16'h0000, 16'h0000, 16'h0000, 5'h00, 1);
    $display("test comparators done");
    for (int j = 0; j < 5; j++) begin
      cyc(24'h12_3000, 16'h0000, 16'h0000, 16'h0000, 5'h01, int'(j == 4));
    end
    rd(8'h20, 16'h0004);
    idle(1);
    cyc(24'h00_0000, 16'h0000, 16'h0000, 16'h0000, 5'h0c, 0);
    cyc(24'h00_0000, 16'h0000, 16'h0000, 16'h0000, 5'h0f, 0);
    cyc(24'h00_0000, 16'h0000, 16'h0000, 16'h0000, 5'h00, 1);
    rd(8'h21, 16'h0005);
    rd(8'h20, 16'h0001);
    run_mode_i <= 1'b0;
    idle(2);
    run_mode_i <= 1'b1;
    idle(1);
    cnt = lim[0];
    grp = 2'd0;
    zf = 1'b0;
    rd(8'h21, 16'h0003);
    idle(1);
    cyc(24'h5a_4000, 16'h0000, 16'h0000, 16'h0000, 5'h01, 1);
    idle(3);
    $display("test counting done");
    complete_run();
  end
endmodule
`default_nettype wire
